// >>> smbus_monitor_register_port_test.sv
// bench: host model on the bus, converter codes driven from here
// assumes design, host model and bound checker compiled first
`timescale 1ns/1ps
module smbus_monitor_register_port_test;
  import smon_pkg::*;
  localparam int CONV = 20;
  localparam int TOUT = 200;
  localparam logic [7:0] ANSWER = {SMON_DEV_ADDR, 1'b0};
  logic       core_clk;
  logic       rst_n;
  logic       sda_oe;
  logic       alert_oe;
  logic       adc_chan;
  logic       vcc_5v_scale;
  logic       scl;
  logic       host_low;
  logic       a;
  logic [9:0] adc_code;
  logic [9:0] code_25v;
  logic [9:0] code_vcc;
  logic [7:0] r;
  logic [7:0] exp_q[$];
  logic [7:0] idx_tab[9] = '{8'h20, 8'h22, 8'h40, 8'h41, 8'h44,
                             8'h45, 8'h48, 8'h49, 8'h30};
  logic [7:0] rst_tab[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'hff, 8'h00, 8'hff, 8'h00};
  int         miscompares;
  int         samples_checked;
  wire logic  sda;
  // open-drain wire, pull-up when nobody pulls
  assign sda = !(sda_oe | host_low);
  smon_port #(.CONV_CYC(CONV), .TIMEOUT_CYC(TOUT)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .alert_i(!alert_oe), .alert_o(),
    .alert_oe(alert_oe), .adc_code(adc_code), .adc_chan(adc_chan),
    .adc_sample(), .vcc_5v_scale(vcc_5v_scale)
  );
  smon_host host (.sda(sda), .scl(scl), .sda_low(host_low));
  always #5 core_clk = ~core_clk;
  // converter answers for the selected channel
  always @(posedge core_clk)
    adc_code <= #1 (adc_chan ? code_vcc : code_25v);
  task automatic check_byte(input string w, input logic [7:0] e,
                            input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic check_bit(input string w, input logic e, input logic s);
    check_byte(w, {7'h0, e}, {7'h0, s});
  endtask
  // the reader notes the expected byte, the monitor compares it
  always @(host.got_byte) begin
    check_byte("read data", exp_q.pop_front(), host.rd_byte);
  end
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v,
                    input logic full);
    logic n;
    host.start();
    host.send_byte(ANSWER, n);
    check_bit("address ack", 1'b0, n);
    host.send_byte(idx, n);
    check_bit("index ack", 1'b0, n);
    if (full) begin
      host.send_byte(v, n);
      check_bit("data ack", 1'b0, n);
    end
    host.stop();
  endtask
  task automatic rd(input logic [6:0] adr, input logic [7:0] e,
                    input logic [7:0] rival);
    logic n;
    exp_q.push_back(e);
    host.start();
    host.send_byte({adr, 1'b1}, n);
    check_bit("read address ack", 1'b0, n);
    host.recv_byte(rival);
    host.stop();
  endtask
  // pointer-only write, then two reads that must agree
  task automatic reg_is(input logic [7:0] idx, input logic [7:0] e);
    wr(idx, 8'h00, 1'b0);
    rd(SMON_DEV_ADDR, e, 8'hff);
    rd(SMON_DEV_ADDR, e, 8'hff);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #900000;
    miscompares++;
    summarize();
  end
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    code_25v = 10'h000;
    code_vcc = 10'h000;
    adc_code = 10'h000;
    r = 8'($urandom(32'h184f));
    cycles(4);
    rst_n = 1'b1;
    cycles(8);
    foreach (idx_tab[i]) begin
      reg_is(idx_tab[i], rst_tab[i]);
    end
    check_bit("supply scaling", 1'b0, vcc_5v_scale);
    $display("test reset_values done");
    // random high limits read back; result register ignores writes
    for (int k = 0; k < 2; k++) begin
      r = 8'($urandom());
      wr(k ? SMON_REG_HI_VCC : SMON_REG_HI_25V, r, 1'b1);
      reg_is(k ? SMON_REG_HI_VCC : SMON_REG_HI_25V, r);
    end
    wr(SMON_REG_RES_25V, r, 1'b1);
    reg_is(SMON_REG_RES_25V, 8'h00);
    wr(SMON_REG_HI_25V, 8'hff, 1'b1);
    wr(SMON_REG_HI_VCC, 8'hff, 1'b1);
    $display("test limits done");
    // nominal and saturated codes keep their upper eight bits
    code_25v = 10'h300;
    code_vcc = 10'h3ff;
    cycles(1600);
    reg_is(SMON_REG_RES_25V, 8'hc0);
    reg_is(SMON_REG_RES_VCC, 8'hff);
    check_bit("alert idle", 1'b0, alert_oe);
    $display("test conversion done");
    // limit under the reading: status, alert, answer, arbitration
    wr(SMON_REG_HI_25V, 8'hbf, 1'b1);
    cycles(10);
    check_bit("alert raised", 1'b1, alert_oe);
    reg_is(SMON_REG_STATUS, 8'h01);
    rd(SMON_ALERT_RESP, 8'h5a, 8'h5a);
    check_bit("alert after lost answer", 1'b1, alert_oe);
    rd(SMON_ALERT_RESP, ANSWER, 8'hff);
    check_bit("alert with fault", 1'b1, alert_oe);
    wr(SMON_REG_HI_25V, 8'hff, 1'b1);
    cycles(10);
    rd(SMON_ALERT_RESP, ANSWER, 8'hff);
    check_bit("alert released", 1'b0, alert_oe);
    // host services status: sticky bit seen once, then cleared by the read
    wr(SMON_REG_STATUS, 8'h00, 1'b0);
    rd(SMON_DEV_ADDR, 8'h01, 8'hff);
    rd(SMON_DEV_ADDR, 8'h00, 8'hff);
    $display("test alert done");
    // stall with clock low: dropped when enabled, kept when disabled
    for (int k = 0; k < 2; k++) begin
      wr(SMON_REG_CONFIG1, k ? 8'hc0 : 8'h80, 1'b1);
      host.start();
      host.send_byte(ANSWER, a);
      #(TOUT * 15);
      host.send_byte(SMON_REG_CONFIG1, a);
      check_bit("ack after stall", k == 0, a);
      host.send_byte(8'h80, a);
      host.stop();
    end
    rd(SMON_DEV_ADDR, 8'h80, 8'hff);
    check_bit("supply scaling", 1'b1, vcc_5v_scale);
    $display("test timeout done");
    // reset in mid-run returns configuration and pins to idle
    rst_n = 1'b0;
    cycles(2);
    rst_n = 1'b1;
    cycles(8);
    check_bit("scaling after reset", 1'b0, vcc_5v_scale);
    reg_is(SMON_REG_CONFIG1, SMON_RST_CONFIG1);
    $display("test mid_reset done");
    summarize();
  end
endmodule

// >>> smon_host.sv
// bus host model, bit-banged, able to act as a rival alert device
// assumes sda is the resolved wire with a pull-up
`timescale 1ns/1ps
module smon_host (
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  localparam int HALF = 80; // bus clock period 160 ns
  logic [7:0] rd_byte;
  event       got_byte;
  // clock stands high outside frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
    rd_byte = 8'h0;
  end
  task automatic start();
    sda_low = 1'b1;
    #HALF scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF/2) sda_low = 1'b1;
    #(HALF/2) scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
  // data changes only in the low half, sampled mid-high
  task automatic clk_bit(input logic b, output logic seen);
    #(HALF/2) sda_low = !b;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) seen = sda;
    #(HALF/2) scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, nack);
  endtask
  // zero bits of rival are pulled, as a competing device would
  task automatic recv_byte(input logic [7:0] rival);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(rival[i], s);
      rd_byte[i] = s;
    end
    clk_bit(1'b1, s);
    -> got_byte;
  endtask
endmodule

// >>> smon_pkg.sv
// shared constants for the monitor register port: register map, reset
// values, configuration fields and timing counts
// assumes a 100 MHz core clock
package smon_pkg;

  // register indices as seen in the pointer
  localparam logic [7:0] SMON_REG_RES_25V   = 8'h20;
  localparam logic [7:0] SMON_REG_RES_VCC   = 8'h22;
  localparam logic [7:0] SMON_REG_CONFIG1   = 8'h40;
  localparam logic [7:0] SMON_REG_STATUS    = 8'h41;
  localparam logic [7:0] SMON_REG_LO_25V    = 8'h44;
  localparam logic [7:0] SMON_REG_HI_25V    = 8'h45;
  localparam logic [7:0] SMON_REG_LO_VCC    = 8'h48;
  localparam logic [7:0] SMON_REG_HI_VCC    = 8'h49;

  // reset values
  localparam logic [7:0] SMON_RST_RESULT    = 8'h00;
  localparam logic [7:0] SMON_RST_CONFIG1   = 8'h00;
  localparam logic [7:0] SMON_RST_LO_LIMIT  = 8'h00;
  localparam logic [7:0] SMON_RST_HI_LIMIT  = 8'hff;
  localparam logic [7:0] SMON_RST_POINTER   = 8'h00;

  // configuration one fields
  localparam int SMON_CFG_TIMEOUT_DIS_BIT   = 6;
  localparam int SMON_CFG_VCC_5V_BIT        = 7;

  // status fields
  localparam int SMON_STS_25V_BIT           = 0;
  localparam int SMON_STS_VCC_BIT           = 1;

  // bus addresses
  localparam logic [6:0] SMON_DEV_ADDR      = 7'h2e;
  localparam logic [6:0] SMON_ALERT_RESP    = 7'h0c;

  // timing
  localparam int SMON_CLK_MHZ               = 100;
  localparam int SMON_CONV_TIME_US          = 711;
  localparam int SMON_CONV_CYC = SMON_CONV_TIME_US * SMON_CLK_MHZ;
  localparam int SMON_TIMEOUT_MS            = 25;
  localparam int SMON_TIMEOUT_CYC = SMON_TIMEOUT_MS * 1000 * SMON_CLK_MHZ;
  localparam int SMON_AVG_COUNT             = 16;

  // slave states
  typedef enum logic [2:0] {
    SMON_ST_IDLE     = 3'b000,
    SMON_ST_ADDR     = 3'b001,
    SMON_ST_ACK_ADDR = 3'b010,
    SMON_ST_RX       = 3'b011,
    SMON_ST_ACK_RX   = 3'b100,
    SMON_ST_TX       = 3'b101,
    SMON_ST_ACK_TX   = 3'b110
  } smon_state_type;

endpackage

// >>> smon_port.sv
// smbus slave register port of the voltage monitor, with converter
// sequencing, 16-fold averaging, limit checks and the alert line
// assumes the analog converter presents adc_code for adc_chan in the cycle
// before adc_sample pulses, when the block samples it; sda and alert are open drain outside
`timescale 1ns/1ps
module smon_port
  import smon_pkg::*;
#(
  parameter int CONV_CYC    = SMON_CONV_CYC,
  parameter int TIMEOUT_CYC = SMON_TIMEOUT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       alert_i,
  output logic            alert_o,
  output logic            alert_oe,
  input  wire logic [9:0] adc_code,
  output logic            adc_chan,
  output logic            adc_sample,
  output logic            vcc_5v_scale
);

  localparam logic [16:0] CONV_LAST = 17'(CONV_CYC - 1);
  localparam logic [21:0] TO_LAST   = 22'(TIMEOUT_CYC - 1);
  localparam logic [3:0]  AVG_LAST  = 4'(SMON_AVG_COUNT - 1);

  logic            rst_pipe_q;
  logic            rst_sync_n;
  logic            scl_s;
  logic            sda_s;
  logic            scl_prev_q;
  logic            sda_prev_q;
  smon_state_type  state_q;
  logic [3:0]      bit_cnt_q;
  logic [7:0]      rx_sh_q;
  logic [7:0]      tx_sh_q;
  logic            drive_q;
  logic            is_read_q;
  logic            is_ara_q;
  logic            first_byte_q;
  logic [21:0]     idle_cnt_q;
  logic [7:0]      ptr_q;
  logic [7:0]      cfg_q;
  logic [7:0]      res_25v_q;
  logic [7:0]      res_vcc_q;
  logic [7:0]      lo_25v_q;
  logic [7:0]      hi_25v_q;
  logic [7:0]      lo_vcc_q;
  logic [7:0]      hi_vcc_q;
  logic [1:0]      status_q;
  logic            alert_q;
  logic [16:0]     conv_cnt_q;
  logic [3:0]      avg_cnt_q;
  logic [13:0]     acc_q;
  logic            chan_q;
  logic            sample_q;

  // release the reset through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_pipe_q <= 1'b1;
      rst_sync_n <= rst_pipe_q;
    end
  end

  smon_sync3 #(.RESET_VAL(1'b1)) u_sync_scl (
    .clk   (core_clk),
    .rst_n (rst_sync_n),
    .d     (scl_i),
    .q     (scl_s)
  );

  smon_sync3 #(.RESET_VAL(1'b1)) u_sync_sda (
    .clk   (core_clk),
    .rst_n (rst_sync_n),
    .d     (sda_i),
    .q     (sda_s)
  );

  // bus events from the filtered lines
  wire scl_rise  = scl_s & ~scl_prev_q;
  wire scl_fall  = ~scl_s & scl_prev_q;
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire bus_edge  = (scl_s ^ scl_prev_q) | (sda_s ^ sda_prev_q);

  // address decode of the received first byte
  wire addr_own  = (rx_sh_q[7:1] == SMON_DEV_ADDR);
  wire addr_ara  = (rx_sh_q[7:1] == SMON_ALERT_RESP) & rx_sh_q[0] & alert_q;
  wire addr_hit  = addr_own | addr_ara;
  wire byte_done = scl_fall & (bit_cnt_q == 4'd8);

  // timeout only while a transaction is open and bit 6 is clear
  wire to_enable = ~cfg_q[SMON_CFG_TIMEOUT_DIS_BIT];
  wire timed_out = to_enable & (state_q != SMON_ST_IDLE)
                   & (idle_cnt_q == TO_LAST);

  // a released bit read back low means another sender won
  wire arb_lost  = scl_rise & ~drive_q & ~sda_s
                   & (bit_cnt_q != 4'd8);

  // register read selection by pointer, unmapped reads as zero
  wire [7:0] status_rd = {6'h00, status_q};
  wire [7:0] reg_rdata =
    (ptr_q == SMON_REG_RES_25V) ? res_25v_q :
    (ptr_q == SMON_REG_RES_VCC) ? res_vcc_q :
    (ptr_q == SMON_REG_CONFIG1) ? cfg_q :
    (ptr_q == SMON_REG_STATUS)  ? status_rd :
    (ptr_q == SMON_REG_LO_25V)  ? lo_25v_q :
    (ptr_q == SMON_REG_HI_25V)  ? hi_25v_q :
    (ptr_q == SMON_REG_LO_VCC)  ? lo_vcc_q :
    (ptr_q == SMON_REG_HI_VCC)  ? hi_vcc_q : 8'h00;
  wire [7:0] tx_byte = is_ara_q ? {SMON_DEV_ADDR, 1'b0} : reg_rdata;

  // write strobes: the second and later bytes of a write
  wire data_wr  = byte_done & (state_q == SMON_ST_RX) & ~first_byte_q;
  wire ptr_wr   = byte_done & (state_q == SMON_ST_RX) & first_byte_q;
  wire wr_cfg   = data_wr & (ptr_q == SMON_REG_CONFIG1);
  wire wr_lo25  = data_wr & (ptr_q == SMON_REG_LO_25V);
  wire wr_hi25  = data_wr & (ptr_q == SMON_REG_HI_25V);
  wire wr_lovcc = data_wr & (ptr_q == SMON_REG_LO_VCC);
  wire wr_hivcc = data_wr & (ptr_q == SMON_REG_HI_VCC);

  // the status byte read clears it; sending it counts as the read
  wire sts_read = (state_q == SMON_ST_ACK_ADDR) & scl_fall & is_read_q
                  & ~is_ara_q & (ptr_q == SMON_REG_STATUS);
  wire ara_done = (state_q == SMON_ST_ACK_TX) & scl_rise & is_ara_q;

  // slave line history and inactivity counter
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      idle_cnt_q <= 22'h000000;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      if (bus_edge || state_q == SMON_ST_IDLE || timed_out) begin
        idle_cnt_q <= 22'h000000;
      end else begin
        idle_cnt_q <= idle_cnt_q + 22'h000001;
      end
    end
  end

  // slave byte engine; sda changes only after scl falls
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q      <= SMON_ST_IDLE;
      bit_cnt_q    <= 4'h0;
      rx_sh_q      <= 8'h00;
      tx_sh_q      <= 8'h00;
      drive_q      <= 1'b0;
      is_read_q    <= 1'b0;
      is_ara_q     <= 1'b0;
      first_byte_q <= 1'b0;
    end else if (timed_out || stop_det) begin
      state_q <= SMON_ST_IDLE;
      drive_q <= 1'b0;
    end else if (start_det) begin
      state_q   <= SMON_ST_ADDR;
      bit_cnt_q <= 4'h0;
      drive_q   <= 1'b0;
    end else begin
      case (state_q)
        SMON_ST_ADDR, SMON_ST_RX: begin
          if (scl_rise) begin
            rx_sh_q   <= {rx_sh_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            if (state_q == SMON_ST_RX) begin
              drive_q      <= 1'b1;
              first_byte_q <= 1'b0;
              state_q      <= SMON_ST_ACK_RX;
            end else if (addr_hit) begin
              drive_q      <= 1'b1;
              is_read_q    <= rx_sh_q[0];
              is_ara_q     <= addr_ara;
              first_byte_q <= 1'b1;
              state_q      <= SMON_ST_ACK_ADDR;
            end else begin
              state_q <= SMON_ST_IDLE;
            end
          end
        end
        SMON_ST_ACK_ADDR, SMON_ST_ACK_RX: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (is_read_q) begin
              tx_sh_q <= tx_byte;
              drive_q <= ~tx_byte[7];
              state_q <= SMON_ST_TX;
            end else begin
              drive_q <= 1'b0;
              state_q <= SMON_ST_RX;
            end
          end
        end
        SMON_ST_TX: begin
          if (arb_lost) begin
            drive_q <= 1'b0;
            state_q <= SMON_ST_IDLE;
          end else if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == 4'd8) begin
              drive_q <= 1'b0;
              state_q <= SMON_ST_ACK_TX;
            end else begin
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              drive_q <= ~tx_sh_q[6];
            end
          end
        end
        SMON_ST_ACK_TX: begin
          // not-acknowledge ends the read; an acknowledge repeats the byte
          if (scl_rise) begin
            state_q   <= sda_s ? SMON_ST_IDLE : SMON_ST_ACK_RX;
            is_read_q <= 1'b1;
          end
        end
        default: begin
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // pointer and writable registers; reads never touch the pointer
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr_q    <= SMON_RST_POINTER;
      cfg_q    <= SMON_RST_CONFIG1;
      lo_25v_q <= SMON_RST_LO_LIMIT;
      hi_25v_q <= SMON_RST_HI_LIMIT;
      lo_vcc_q <= SMON_RST_LO_LIMIT;
      hi_vcc_q <= SMON_RST_HI_LIMIT;
    end else begin
      if (ptr_wr) ptr_q <= rx_sh_q;
      if (wr_cfg) cfg_q <= rx_sh_q;
      if (wr_lo25) lo_25v_q <= rx_sh_q;
      if (wr_hi25) hi_25v_q <= rx_sh_q;
      if (wr_lovcc) lo_vcc_q <= rx_sh_q;
      if (wr_hivcc) hi_vcc_q <= rx_sh_q;
    end
  end

  // converter pacing: one sample strobe per conversion time
  wire conv_tick = (conv_cnt_q == CONV_LAST);
  wire avg_done  = conv_tick & (avg_cnt_q == AVG_LAST);
  // sum of sixteen 10-bit codes never exceeds 14 bits, so the mean
  // saturates at 1023 by itself
  wire [13:0] acc_sum = acc_q + {4'h0, adc_code};
  wire [7:0]  avg_top = acc_sum[13:6];

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      conv_cnt_q <= 17'h00000;
      avg_cnt_q  <= 4'h0;
      acc_q      <= 14'h0000;
      chan_q     <= 1'b0;
      sample_q   <= 1'b0;
    end else begin
      sample_q   <= conv_tick;
      conv_cnt_q <= conv_tick ? 17'h00000 : conv_cnt_q + 17'h00001;
      if (conv_tick) begin
        avg_cnt_q <= avg_cnt_q + 4'h1;
        acc_q     <= avg_done ? 14'h0000 : acc_sum;
      end
      if (avg_done) chan_q <= ~chan_q;
    end
  end

  // averaged results land in the register of the channel just measured
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      res_25v_q <= SMON_RST_RESULT;
      res_vcc_q <= SMON_RST_RESULT;
    end else if (avg_done) begin
      if (chan_q) res_vcc_q <= avg_top;
      else res_25v_q <= avg_top;
    end
  end

  // limit checks on the stored eight-bit results
  wire viol_25v = (res_25v_q < lo_25v_q) | (res_25v_q > hi_25v_q);
  wire viol_vcc = (res_vcc_q < lo_vcc_q) | (res_vcc_q > hi_vcc_q);
  wire viol_any = viol_25v | viol_vcc;

  // status is sticky and cleared by reading it; a breach wins the clear
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_q <= 2'b00;
      alert_q  <= 1'b0;
    end else begin
      status_q[SMON_STS_25V_BIT] <= viol_25v |
        (status_q[SMON_STS_25V_BIT] & ~sts_read);
      status_q[SMON_STS_VCC_BIT] <= viol_vcc |
        (status_q[SMON_STS_VCC_BIT] & ~sts_read);
      if (viol_any) begin
        alert_q <= 1'b1;
      end else if (ara_done) begin
        alert_q <= 1'b0;
      end
    end
  end

  // the alert line level is not needed: arbitration happens on sda
  wire unused_alert = alert_i;

  assign sda_o        = 1'b0;
  assign sda_oe       = drive_q;
  assign alert_o      = 1'b0;
  assign alert_oe     = alert_q & ~unused_alert | alert_q;
  assign adc_chan     = chan_q;
  assign adc_sample   = sample_q;
  assign vcc_5v_scale = cfg_q[SMON_CFG_VCC_5V_BIT];

endmodule

// >>> smon_port_asserts.sv
// assertion checker for the monitor register port, bound below
// assumes one core clock domain and the active-low rst_n
`timescale 1ns/1ps
module smon_port_asserts
  import smon_pkg::*;
#(
  parameter int CONV_CYC    = SMON_CONV_CYC,
  parameter int TIMEOUT_CYC = SMON_TIMEOUT_CYC
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       alert_i,
  input wire logic       alert_o,
  input wire logic       alert_oe,
  input wire logic [9:0] adc_code,
  input wire logic       adc_chan,
  input wire logic       adc_sample,
  input wire logic       vcc_5v_scale
);
  logic [31:0] gap_q;
  logic        seen_q;
  logic [4:0]  smp_q;
  logic        chan_q;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // cycles since the last sample, samples taken on this channel
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
      smp_q  <= 5'h0;
      chan_q <= 1'b0;
    end else begin
      gap_q  <= adc_sample ? 32'h0 : gap_q + 32'h1;
      seen_q <= seen_q | adc_sample;
      smp_q  <= (adc_chan != chan_q) ? 5'h0 : smp_q + 5'(adc_sample);
      chan_q <= adc_chan;
    end
  end
  sda_const_a:
    assert property (sda_o == 1'b0) else $error("sda value not zero");
  alert_const_a:
    assert property (alert_o == 1'b0) else $error("alert value not zero");
  reset_quiet_a:
    assert property ($rose(rst_n) |-> (!sda_oe && !alert_oe) [*4])
    else $error("pins driven just after reset");
  sample_pulse_a:
    assert property (adc_sample |=> !adc_sample)
    else $error("sample strobe too long");
  sample_gap_a:
    assert property (adc_sample && seen_q |-> gap_q == CONV_CYC - 1)
    else $error("conversion period wrong");
  chan_swap_a:
    assert property (adc_chan != chan_q |-> smp_q + 5'(adc_sample) == 5'h10)
    else $error("channel changed early");
  ack_drive_a:
    assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data pulled while clock high");
  alert_clear_a:
    assert property ($fell(alert_oe) |-> scl_i)
    else $error("alert released off a bus clock");
  cover property (adc_chan != chan_q);
  cover property ($rose(alert_oe));
  cover property ($fell(alert_oe));
endmodule

bind smon_port smon_port_asserts #(
  .CONV_CYC(CONV_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)
) chk (
  .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .alert_i(alert_i), .alert_o(alert_o),
  .alert_oe(alert_oe), .adc_code(adc_code), .adc_chan(adc_chan),
  .adc_sample(adc_sample), .vcc_5v_scale(vcc_5v_scale)
);

// >>> smon_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes d is asynchronous to clk
`timescale 1ns/1ps
module smon_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic ff1_q;
  logic ff2_q;
  logic ff3_q;

  // first stage feeds only the second; the output follows once 2 and 3 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1_q <= RESET_VAL;
      ff2_q <= RESET_VAL;
      ff3_q <= RESET_VAL;
      q     <= RESET_VAL;
    end else begin
      ff1_q <= d;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      if (ff2_q == ff3_q) begin
        q <= ff3_q;
      end
    end
  end

endmodule
